// ### rtl/rec_pkg.sv
// Constants for the regulator enable control block
package rec_pkg;
   localparam logic [7:0] REC_CTRL_ADDR = 8'h02;
   localparam logic [7:0] REC_STAT_ADDR = 8'h03;
   localparam logic [7:0] REC_SEQ1_ADDR = 8'h04;
   localparam logic [7:0] REC_SEQ2_ADDR = 8'h05;
   localparam logic [7:0] REC_CTRL_RST = 8'h00;
   localparam logic [7:0] REC_STAT_RST = 8'h00;
   localparam logic [7:0] REC_SEQ_RST = 8'h00;
   localparam logic [7:0] REC_CTRL_MASK = 8'h7f;
   localparam logic [7:0] REC_STAT_MASK = 8'h3f;
   localparam logic [7:0] REC_SEQ1_MASK = 8'h3f;
   localparam logic [7:0] REC_SEQ2_MASK = 8'h7f;
   localparam int REC_BIT_BST = 0;
   localparam int REC_BIT_AVDD = 1;
   localparam int REC_BIT_VGON = 2;
   localparam int REC_BIT_VGOFF = 3;
   localparam int REC_BIT_GS = 4;
   localparam int REC_BIT_VCOM = 5;
   localparam int REC_BIT_TRIG = 6;
   localparam int REC_STAGES = 4;
   localparam logic [7:0] REC_STEP_CYC = 8'h10;
   typedef enum logic [1:0] {REC_IDLE, REC_UP, REC_DOWN} rec_seq_t;
endpackage

// ### rtl/rec_top.sv
// Regulator enable control and power status logic
`timescale 1ns/10ps
module rec_top
   import rec_pkg::*;
#(
   parameter int STEP_CYC = 16
) (
   input wire logic ref_clk, // 50 MHz system clock
   input wire logic nrst, // Synchronous reset, active low
   input wire logic wr_en, // Register write strobe from serial slave
   input wire logic [7:0] wr_addr, // Register write address
   input wire logic [7:0] wr_data, // Register write data
   input wire logic [7:0] rd_addr, // Register read address
   input wire logic en_autoseq, // Automatic sequencing selected
   input wire logic bst_ready, // Boost reports ready (pin)
   input wire logic avdd_good, // Analog rail power-good (pin)
   input wire logic delay_pin, // Delay pin above threshold (pin)
   input wire logic [3:0] stage_ready, // Stage settled: 3 vgoff 2 vgon 1 avdd 0 boost (pins)
   output logic [7:0] rd_data, // Registered read data
   output logic [5:0] reg_enable, // Enables: 5 buffer 4 shading 3..0 stages
   output logic seq_busy // Sequence in progress
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [7:0] meta_q;
   logic [7:0] sync_q;
   logic auto_q;
   logic bst_rdy_s;
   logic avdd_good_s;
   logic delay_s;
   logic [3:0] stg_rdy_s;

   // Two flops on every pin; only sync_q is read by logic
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         meta_q <= 8'h00;
         sync_q <= 8'h00;
      end else begin
         meta_q <= {stage_ready, delay_pin, avdd_good, bst_ready, 1'b0};
         sync_q <= meta_q;
      end
   end
   assign bst_rdy_s = sync_q[1];
   assign avdd_good_s = sync_q[2];
   assign delay_s = sync_q[3];
   assign stg_rdy_s = sync_q[7:4];

   // Configuration selection from same clock logic
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         auto_q <= 1'b0;
      end else begin
         auto_q <= en_autoseq;
      end
   end

   // ----------------------------------------------------------------
   // Control and sequence programming registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] seq1_q;
   logic [7:0] seq2_q;
   logic [7:0] stat_q;
   rec_seq_t seq_st_q;
   logic wr_ctrl;
   logic boost_ok;

   assign wr_ctrl = wr_en && (wr_addr == REC_CTRL_ADDR);
   assign boost_ok = ctrl_q[REC_BIT_BST] && stat_q[REC_BIT_BST];

   // Write merge; downstream enables refused until boost is up and ready
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = wr_data & REC_CTRL_MASK;
         if (!boost_ok) begin
            ctrl_d[REC_BIT_AVDD] = 1'b0;
            ctrl_d[REC_BIT_VGON] = 1'b0;
            ctrl_d[REC_BIT_VGOFF] = 1'b0;
         end
      end
      // Losing the boost drops the downstream enables too
      if (!ctrl_d[REC_BIT_BST]) begin
         ctrl_d[REC_BIT_AVDD] = 1'b0;
         ctrl_d[REC_BIT_VGON] = 1'b0;
         ctrl_d[REC_BIT_VGOFF] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ctrl_q <= REC_CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Programming is frozen while a sequence runs
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         seq1_q <= REC_SEQ_RST;
         seq2_q <= REC_SEQ_RST;
      end else if (wr_en && seq_st_q == REC_IDLE) begin
         if (wr_addr == REC_SEQ1_ADDR) begin
            seq1_q <= wr_data & REC_SEQ1_MASK;
         end
         if (wr_addr == REC_SEQ2_ADDR) begin
            seq2_q <= wr_data & REC_SEQ2_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Automatic sequencer
   // ----------------------------------------------------------------
   logic seq_on_q;
   logic [7:0] step_q;
   logic [2:0] slot_q;
   logic [3:0] auto_en_q;
   logic trig;
   localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);

   assign trig = ctrl_q[REC_BIT_TRIG];

   // Stages come up in order boost, rail, positive, negative; down in reverse.
   // Slot programming is only stored and read back here; the matrix itself stays off-block.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         seq_st_q <= REC_IDLE;
         seq_on_q <= 1'b0;
         step_q <= 8'h00;
         slot_q <= 3'h0;
         auto_en_q <= 4'h0;
      end else begin
         case (seq_st_q)
            REC_IDLE: begin
               step_q <= 8'h00;
               slot_q <= 3'h0;
               if (!auto_q) begin
                  seq_on_q <= 1'b0;
                  auto_en_q <= 4'h0;
               end else if (trig && !seq_on_q) begin
                  seq_st_q <= REC_UP;
               end else if (!trig && seq_on_q) begin
                  seq_st_q <= REC_DOWN;
               end
            end
            REC_UP: begin
               if (step_q == STEP_LAST) begin
                  step_q <= 8'h00;
                  auto_en_q[slot_q[1:0]] <= 1'b1;
                  slot_q <= slot_q + 3'h1;
                  if (slot_q == 3'(REC_STAGES - 1)) begin
                     seq_st_q <= REC_IDLE;
                     seq_on_q <= 1'b1;
                  end
               end else if (slot_q != 3'h1 || stat_q[REC_BIT_BST]) begin
                  step_q <= step_q + 8'h01;
               end
            end
            REC_DOWN: begin
               if (step_q == STEP_LAST) begin
                  step_q <= 8'h00;
                  auto_en_q[2'(3 - slot_q[1:0])] <= 1'b0;
                  slot_q <= slot_q + 3'h1;
                  if (slot_q == 3'(REC_STAGES - 1)) begin
                     seq_st_q <= REC_IDLE;
                     seq_on_q <= 1'b0;
                  end
               end else begin
                  step_q <= step_q + 8'h01;
               end
            end
            default: begin
               seq_st_q <= REC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Enables and status
   // ----------------------------------------------------------------
   logic [3:0] stage_en;
   logic [5:0] en_d;

   assign stage_en = auto_q ? auto_en_q : ctrl_q[3:0];

   always_comb begin
      en_d[3:0] = stage_en;
      // Buffer follows the analog rail switch status and good flag unless disabled
      en_d[REC_BIT_VCOM] = !ctrl_q[REC_BIT_VCOM] && stat_q[REC_BIT_AVDD] && avdd_good_s;
      // Shading waits for all soft-starts and the delay pin
      en_d[REC_BIT_GS] = !ctrl_q[REC_BIT_GS] && (&stat_q[3:0]) && delay_s;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         reg_enable <= 6'h00;
         seq_busy <= 1'b0;
      end else begin
         reg_enable <= en_d;
         seq_busy <= (seq_st_q != REC_IDLE);
      end
   end

   // Status: stages enabled and settled, shading enabled, buffer enabled with rail good; a status bit lags its enable by one cycle
   // Boost status also needs its ready pin, so downstream enables wait on it
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         stat_q <= REC_STAT_RST;
      end else begin
         stat_q[3:0] <= reg_enable[3:0] & stg_rdy_s & {3'h7, bst_rdy_s};
         stat_q[REC_BIT_GS] <= reg_enable[REC_BIT_GS];
         stat_q[REC_BIT_VCOM] <= reg_enable[REC_BIT_VCOM] && avdd_good_s;
         stat_q[7:6] <= 2'h0;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rd_data <= 8'h00;
      end else begin
         case (rd_addr)
            REC_CTRL_ADDR: rd_data <= ctrl_q & REC_CTRL_MASK;
            REC_STAT_ADDR: rd_data <= stat_q & REC_STAT_MASK;
            REC_SEQ1_ADDR: rd_data <= seq1_q;
            REC_SEQ2_ADDR: rd_data <= seq2_q;
            default: rd_data <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_up_start;
      auto_q && trig && !seq_on_q && seq_st_q == REC_IDLE;
   endsequence

   AST_DOWNSTREAM_GATED: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!auto_q && !ctrl_q[REC_BIT_BST]) |-> ctrl_q[3:1] == 3'h0)
      else $error("downstream enable set without boost");
   AST_SWITCH_REFUSED: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr_ctrl && !boost_ok && !ctrl_q[REC_BIT_AVDD]) |=> !ctrl_q[REC_BIT_AVDD])
      else $error("switch closed while boost not ready");
   AST_UP_STARTS: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_up_start |=> seq_st_q == REC_UP ##1 seq_busy)
      else $error("power-on sequence did not start");
   AST_DOWN_STARTS: assert property (@(posedge ref_clk) disable iff (!nrst)
      (auto_q && !trig && seq_on_q && seq_st_q == REC_IDLE) |=> seq_st_q == REC_DOWN)
      else $error("power-down sequence did not start");
   AST_PROG_FROZEN: assert property (@(posedge ref_clk) disable iff (!nrst)
      (seq_st_q != REC_IDLE) |=> $stable(seq1_q) && $stable(seq2_q))
      else $error("sequence programming changed during sequence");
   AST_TRIG_IGNORED: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!auto_q && seq_st_q == REC_IDLE) |=> seq_st_q == REC_IDLE)
      else $error("trigger acted with auto sequencing off");
   AST_BUFFER_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
      ctrl_q[REC_BIT_VCOM] |=> !reg_enable[REC_BIT_VCOM])
      else $error("buffer enabled while disabled");
   AST_SHADING_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
      ctrl_q[REC_BIT_GS] |=> !reg_enable[REC_BIT_GS])
      else $error("shading enabled while disabled");
   AST_STATUS_CAUSE: assert property (@(posedge ref_clk) disable iff (!nrst)
      stat_q[REC_BIT_VGON] |-> $past(reg_enable[REC_BIT_VGON]))
      else $error("status set without enable");
   AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!nrst)
      ctrl_q[7] == 1'b0 && stat_q[7:6] == 2'h0)
      else $error("unused bits not zero");

   // Sequence ends: the last slot hands over to idle with every stage set or cleared
   sequence s_up_last;
      seq_st_q == REC_UP && step_q == STEP_LAST && slot_q == 3'(REC_STAGES - 1);
   endsequence

   sequence s_down_last;
      seq_st_q == REC_DOWN && step_q == STEP_LAST && slot_q == 3'(REC_STAGES - 1);
   endsequence

   AST_UP_COMPLETES: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_up_last |=> seq_on_q && seq_st_q == REC_IDLE && auto_en_q == 4'hf)
      else $error("power-on sequence did not complete");
   AST_DOWN_COMPLETES: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_down_last |=> !seq_on_q && seq_st_q == REC_IDLE && auto_en_q == 4'h0)
      else $error("power-down sequence did not complete");
   AST_BUSY_SHOWN: assert property (@(posedge ref_clk) disable iff (!nrst)
      (seq_st_q != REC_IDLE) |=> seq_busy)
      else $error("busy flag low during sequence");
   AST_REFUSED_CLEARS: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr_ctrl && !boost_ok) |=> ctrl_q[3:1] == 3'h0)
      else $error("downstream enable accepted without ready boost");
   AST_MANUAL_FOLLOW: assert property (@(posedge ref_clk) disable iff (!nrst)
      !auto_q |=> reg_enable[3:0] == $past(ctrl_q[3:0]))
      else $error("manual enables not following control bits");
   AST_BUFFER_NEEDS: assert property (@(posedge ref_clk) disable iff (!nrst)
      reg_enable[REC_BIT_VCOM] |-> $past(stat_q[REC_BIT_AVDD]) && $past(avdd_good_s))
      else $error("buffer enabled before analog rail good");
   AST_SHADING_NEEDS: assert property (@(posedge ref_clk) disable iff (!nrst)
      reg_enable[REC_BIT_GS] |-> $past(stat_q[3:0]) == 4'hf && $past(delay_s))
      else $error("shading enabled before stages and delay pin");
   AST_BOOST_STATUS: assert property (@(posedge ref_clk) disable iff (!nrst)
      stat_q[REC_BIT_BST] |-> $past(reg_enable[REC_BIT_BST]) && $past(bst_rdy_s))
      else $error("boost status set without enable and ready");
   AST_SWITCH_STATUS: assert property (@(posedge ref_clk) disable iff (!nrst)
      stat_q[REC_BIT_AVDD] |-> $past(reg_enable[REC_BIT_AVDD]))
      else $error("switch status set while switch open");
endmodule // rec_top

// ### testbench/rec_host_model.sv
// Host bus master model for the register write and read ports
`timescale 1ns/10ps
module rec_host_model
   import rec_pkg::*;
(
   input wire logic ref_clk, // System clock
   output logic wr_en, // Write strobe
   output logic [7:0] wr_addr, // Write address
   output logic [7:0] wr_data, // Write data
   output logic [7:0] rd_addr, // Read address
   input wire logic [7:0] rd_data // Registered read data
);
   // ----------------------------------------
   // Bus idle state
   // ----------------------------------------
   initial begin
      wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
      rd_addr = 8'h00;
   end
   // One-cycle write; address and data are scrambled afterwards so stale values never look valid
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      wr_addr <= ~a;
      wr_data <= ~d;
   endtask
   // Read data is registered, so sample well after the edge that loads it
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      rd_addr <= a;
      repeat (2) @(posedge ref_clk);
      #1;
      d = rd_data;
   endtask
endmodule // rec_host_model

// ### testbench/regulator_enable_control_tb_top.sv
// Self-checking testbench for the regulator enable control block
`timescale 1ns/10ps
module regulator_enable_control_tb_top
   import rec_pkg::*;
;
   logic ref_clk, nrst, en_autoseq, bst_ready, avdd_good, delay_pin, wr_en, seq_busy, on;
   logic [3:0] stage_ready;
   logic [7:0] wr_addr, wr_data, rd_addr, rd_data, d, c;
   logic [5:0] reg_enable;
   logic [7:0] corner [4] = '{8'hff, 8'h0e, 8'h0f, 8'h3f};
   int err_count, comparisons;
   // ----------------------------------------
   // Design and host model
   // ----------------------------------------
   rec_top #(.STEP_CYC(4)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr), .en_autoseq(en_autoseq), .bst_ready(bst_ready),
      .avdd_good(avdd_good), .delay_pin(delay_pin), .stage_ready(stage_ready), .rd_data(rd_data),
      .reg_enable(reg_enable), .seq_busy(seq_busy));
   rec_host_model i_host (.ref_clk(ref_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_addr(rd_addr), .rd_data(rd_data));
   // Clock, 20 ns period
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   // Control value after a write; downstream stage bits 3..1 drop unless boost was already up and the write keeps boost on
   function automatic logic [7:0] exp_ctrl(input logic [7:0] v, input logic up);
      logic [7:0] e;
      e = v & REC_CTRL_MASK;
      if (!(v[0] && up)) e[3:1] = 3'h0;
      return e;
   endfunction
   // Status with every pin high: buffer needs the switch, shading needs all stages
   function automatic logic [7:0] exp_stat(input logic [7:0] v);
      return {2'h0, ~v[5] & v[1], ~v[4] & (v[3:0] == 4'hf), v[3:0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      i_host.read(a, v);
      chk(v, exp);
   endtask
   task automatic settle();
      repeat (8) @(posedge ref_clk);
      #1;
   endtask
   task automatic print_verdict();
      if (err_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Bounded wait for the busy flag; running out ends the run
   task automatic wait_busy(input logic v, input int n);
      for (int k = 0; k <= n; k++) begin
         @(posedge ref_clk);
         #1;
         if (seq_busy === v) return;
      end
      err_count++;
      $display("BAD %0t busy flag wait ran out", $time);
      print_verdict();
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      en_autoseq = 1'b0;
      bst_ready = 1'b0;
      avdd_good = 1'b0;
      delay_pin = 1'b0;
      stage_ready = 4'h0;
      err_count = 0;
      comparisons = 0;
      void'($urandom(32'hee5c));
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      rd_chk(REC_CTRL_ADDR, REC_CTRL_RST);
      rd_chk(REC_STAT_ADDR, REC_STAT_RST);
      rd_chk(8'h07, 8'h00);
      // Boost not ready yet, so only the boost bit may stick
      i_host.write(REC_CTRL_ADDR, 8'h0f);
      settle();
      rd_chk(REC_CTRL_ADDR, 8'h01);
      chk({2'h0, reg_enable}, 8'h01);
      @(posedge ref_clk);
      bst_ready <= 1'b1;
      avdd_good <= 1'b1;
      delay_pin <= 1'b1;
      stage_ready <= 4'hf;
      settle();
      on = 1'b1;
      // Corner values first, then random direct-control writes
      for (int i = 0; i < 16; i++) begin
         d = (i < 4) ? corner[i] : 8'($urandom);
         c = exp_ctrl(d, on);
         i_host.write(REC_CTRL_ADDR, d);
         settle();
         on = c[0];
         rd_chk(REC_CTRL_ADDR, c);
         rd_chk(REC_STAT_ADDR, exp_stat(c));
         chk({2'h0, reg_enable}, exp_stat(c));
         chk({7'h0, seq_busy}, 8'h00);
      end
      // Dropping pins must take buffer, shading and boost readiness down
      i_host.write(REC_CTRL_ADDR, 8'h01);
      settle();
      i_host.write(REC_CTRL_ADDR, 8'h0f);
      settle();
      chk({2'h0, reg_enable}, 8'h3f);
      @(posedge ref_clk);
      delay_pin <= 1'b0;
      avdd_good <= 1'b0;
      settle();
      chk({2'h0, reg_enable}, 8'h0f);
      rd_chk(REC_STAT_ADDR, 8'h0f);
      @(posedge ref_clk);
      bst_ready <= 1'b0;
      settle();
      rd_chk(REC_STAT_ADDR, 8'h0e);
      i_host.write(REC_CTRL_ADDR, 8'h0f);
      settle();
      rd_chk(REC_CTRL_ADDR, 8'h01);
      @(posedge ref_clk);
      bst_ready <= 1'b1;
      delay_pin <= 1'b1;
      avdd_good <= 1'b1;
      settle();
      // Automatic power-on with programming frozen while it runs
      i_host.write(REC_CTRL_ADDR, 8'h00);
      en_autoseq <= 1'b1;
      i_host.write(REC_CTRL_ADDR, 8'h40);
      wait_busy(1'b1, 20);
      i_host.write(REC_SEQ1_ADDR, 8'h3f);
      wait_busy(1'b0, 300);
      chk({4'h0, reg_enable[3:0]}, 8'h0f);
      rd_chk(REC_SEQ1_ADDR, REC_SEQ_RST);
      i_host.write(REC_SEQ1_ADDR, 8'h15);
      rd_chk(REC_SEQ1_ADDR, 8'h15);
      i_host.write(REC_CTRL_ADDR, 8'h40);
      settle();
      chk({3'h0, seq_busy, reg_enable[3:0]}, 8'h0f);
      // Power-down, then a second clear that must change nothing
      i_host.write(REC_CTRL_ADDR, 8'h00);
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 300);
      chk({4'h0, reg_enable[3:0]}, 8'h00);
      i_host.write(REC_CTRL_ADDR, 8'h00);
      settle();
      chk({3'h0, seq_busy, reg_enable[3:0]}, 8'h00);
      print_verdict();
   end
endmodule // regulator_enable_control_tb_top
